// >>> oag_pkg.sv
// package: constants and types for the operand address generator
package oag_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] STACK_POINTER_LOW_ADDR = 8'hd9;
  localparam logic [7:0] WORKING_POINTER_0_ADDR = 8'hd6;
  localparam logic [7:0] WORKING_POINTER_1_ADDR = 8'hd7;
  localparam logic [7:0] WORKING_POINTER_0_RST  = 8'hc0;
  localparam logic [7:0] WORKING_POINTER_1_RST  = 8'hc8;
  localparam logic [7:0] STACK_POINTER_RST      = 8'h00;
  localparam logic [7:0] PROTECTED_BASE         = 8'hc0;

  // ***************************************************************
  // operand decode fields
  // ***************************************************************
  localparam logic [3:0] WORKING_NIBBLE = 4'hc;
  localparam int         POINTER_SEL_BIT = 3;

  // ***************************************************************
  // addressing modes
  // ***************************************************************
  typedef enum logic [2:0]
  {
    MODE_REGISTER             = 3'h0,
    MODE_POINTER_VIA_REGISTER = 3'h1,
    MODE_INDEXED_REG          = 3'h2,
    MODE_INDEXED_MEM_SHORT    = 3'h3,
    MODE_INDEXED_MEM_LONG     = 3'h4,
    MODE_ABSOLUTE_ADDRESS     = 3'h5,
    MODE_VECTOR_TABLE_CALL    = 3'h6,
    MODE_PC_OFFSET            = 3'h7
  } oag_mode_e;

  // ***************************************************************
  // instruction classes
  // ***************************************************************
  typedef enum logic [3:0]
  {
    OP_OTHER                     = 4'h0,
    OP_PLAIN_LOAD                = 4'h1,
    OP_PROGRAM_MEMORY_LOAD       = 4'h2,
    OP_EXTERNAL_DATA_LOAD        = 4'h3,
    OP_ABSOLUTE_JUMP             = 4'h4,
    OP_CALL                      = 4'h5,
    OP_BIT_TEST_BRANCH_FALSE     = 4'h6,
    OP_BIT_TEST_BRANCH_TRUE      = 4'h7,
    OP_DECREMENT_BRANCH_NONZERO  = 4'h8,
    OP_COMPARE_INC_BRANCH_EQUAL  = 4'h9,
    OP_COMPARE_INC_BRANCH_UNEQUAL = 4'ha,
    OP_SHORT_RELATIVE_JUMP       = 4'hb
  } oag_op_e;

  // ***************************************************************
  // stack sequencer
  // ***************************************************************
  typedef enum logic [6:0]
  {
    ST_IDLE     = 7'h01,
    ST_PUSH_PCL = 7'h02,
    ST_PUSH_PCH = 7'h04,
    ST_PUSH_FLG = 7'h08,
    ST_POP_FLG  = 7'h10,
    ST_POP_PCH  = 7'h20,
    ST_POP_PCL  = 7'h40
  } oag_state_e;

  typedef enum logic [1:0]
  {
    STK_NONE      = 2'h0,
    STK_CALL      = 2'h1,
    STK_INTERRUPT = 2'h2
  } oag_frame_e;

endpackage : oag_pkg

// >>> oag_operand_address_generator.sv
// module: operand, branch and stack address generation for the core
`timescale 1ns/1ns
// What this block does
// - operand address with upper nibble 1100b is a working-register reference
// - bit 3 picks pointer 0 or 1; pointer high five bits plus low three
// - call pushes program counter; return pops it back
// - interrupt entry pushes program counter and flags, only the program counter if call comes in the same cycle; interrupt return pops both
// - stack pointer decrements before each push, increments after each pop
// - stack pointer is 8-bit at location d9h, reset to 00h
// - stack lives in the 256-byte register file, addressed by 8-bit pointer only
// - register mode uses named register or pair content as operand
// - indirect register: 8-bit content is register address, pair is memory address
// - indirect register access may not reach c0h to ffh of set 1
// - indexed register access adds instruction base to working register offset
// - indexed access may not reach c0h to ffh of set 1
// - indexed memory access adds offset to working register pair base
// - short memory offset is sign-extended, memory accesses only
// - indexed register only for plain load; memory only for its two loads
// - absolute mode takes 16-bit address; jump and call load program counter
// - vector call reads target from low 256 program bytes, upper bits zero
// - vector call mode accepted only for call
// - pc offset mode adds signed displacement to already advanced program counter
// - pc offset mode used by the six branch and short jump instructions
// - register pair: high byte at even address, low byte at odd
// - after reset pointers select c0h-c7h and c8h-cfh
module oag_operand_address_generator
(
  input  wire logic                  sys_clk_in,      // core clock, 25 mhz
  input  wire logic                  resetn_in,       // async reset, active low
  // register port
  input  wire logic [7:0]            reg_addr_in,     // register address
  input  wire logic [7:0]            reg_wdata_in,    // write data
  input  wire logic                  reg_wr_in,       // write strobe
  input  wire logic                  reg_rd_in,       // read strobe
  output logic      [7:0]            reg_rdata_out,   // read data, cycle after strobe
  // address request from the decoder
  input  wire logic                  req_valid_in,    // one-cycle request
  input  wire oag_pkg::oag_mode_e    req_mode_in,     // addressing mode
  input  wire oag_pkg::oag_op_e      req_op_in,       // instruction class
  input  wire logic [7:0]            req_operand_in,  // 8-bit operand field
  input  wire logic [15:0]           req_word_in,     // 16-bit field or offset
  input  wire logic [15:0]           req_pair_in,     // named register pair content
  input  wire logic [7:0]            req_index_in,    // working register content
  input  wire logic                  req_set1_in,     // upper area refers to set 1
  input  wire logic [15:0]           pc_in,           // pc past current instruction
  // answer
  output logic                       res_valid_out,   // one-cycle result strobe
  output logic                       res_error_out,   // illegal mode or range
  output logic [7:0]                 res_reg_addr_out, // register file address
  output logic [7:0]                 res_reg_data_out, // operand value byte
  output logic [15:0]                res_mem_addr_out, // memory or branch address
  output logic                       res_load_pc_out, // result goes to pc
  output logic                       res_vector_out,  // fetch target from low table
  // stack requests
  input  wire logic                  call_in,         // push pc
  input  wire logic                  ret_in,          // pop pc
  input  wire logic                  int_entry_in,    // push pc and flags; pc only when call_in is high too
  input  wire logic                  interrupt_return_in, // pop flags and pc
  input  wire logic [7:0]            flags_in,        // condition flags
  input  wire logic [7:0]            stack_rdata_in,  // register file read data
  output logic                       stack_busy_out,  // sequence running
  output logic                       stack_we_out,    // write strobe to register file
  output logic                       stack_re_out,    // read strobe to register file
  output logic [7:0]                 stack_addr_out,  // stack location
  output logic [7:0]                 stack_wdata_out, // pushed byte
  output logic                       pc_load_out,     // restore pc strobe
  output logic [15:0]                pc_restore_out,  // restored pc
  output logic                       flags_load_out,  // restore flags strobe
  output logic [7:0]                 flags_restore_out // restored flags
);

  // ********
  // state
  // ********
  typedef struct packed
  {
    logic [7:0]          wp0;
    logic [7:0]          wp1;
    logic [7:0]          sp;
    oag_pkg::oag_state_e st;
    logic [15:0]         pc_hold;
    logic [7:0]          flg_hold;
    logic [7:0]          rdata;
    logic                valid;
    logic                error;
    logic [7:0]          reg_addr;
    logic [7:0]          reg_data;
    logic [15:0]         mem_addr;
    logic                load_pc;
    logic                vector;
    logic                we;
    logic                re;
    logic [7:0]          saddr;
    logic [7:0]          swdata;
    logic                pc_load;
    logic [15:0]         pc_rest;
    logic                flg_load;
    logic [7:0]          flg_rest;
    logic                busy;
  } oag_state_s;

  oag_state_s r;
  oag_state_s next_r;

  // ********
  // helpers
  // ********
  function automatic logic [7:0] map_working(input logic [7:0] a, input logic [7:0] p0, input logic [7:0] p1);
    logic [7:0] p;
    p = a[oag_pkg::POINTER_SEL_BIT] ? p1 : p0;
    if (a[7:4] == oag_pkg::WORKING_NIBBLE)
      map_working = {p[7:3], a[2:0]};
    else
      map_working = a;
  endfunction : map_working

  // upper area of set 1 is only for direct register access
  function automatic logic in_protected(input logic [7:0] a, input logic set1);
    in_protected = set1 && (a >= oag_pkg::PROTECTED_BASE);
  endfunction : in_protected

  function automatic logic is_branch(input oag_pkg::oag_op_e op);
    case (op)
      oag_pkg::OP_BIT_TEST_BRANCH_FALSE,
      oag_pkg::OP_BIT_TEST_BRANCH_TRUE,
      oag_pkg::OP_DECREMENT_BRANCH_NONZERO,
      oag_pkg::OP_COMPARE_INC_BRANCH_EQUAL,
      oag_pkg::OP_COMPARE_INC_BRANCH_UNEQUAL,
      oag_pkg::OP_SHORT_RELATIVE_JUMP: is_branch = 1'b1;
      default:                         is_branch = 1'b0;
    endcase
  endfunction : is_branch

  function automatic logic is_mem_load(input oag_pkg::oag_op_e op);
    is_mem_load = (op == oag_pkg::OP_PROGRAM_MEMORY_LOAD) || (op == oag_pkg::OP_EXTERNAL_DATA_LOAD);
  endfunction : is_mem_load

  // ********
  // next state
  // ********
  always_comb
  begin
    logic [7:0] ea;
    ea = 8'h00;
    next_r = r;
    next_r.valid    = 1'b0;
    next_r.we       = 1'b0;
    next_r.re       = 1'b0;
    next_r.pc_load  = 1'b0;
    next_r.flg_load = 1'b0;

    // register port; pointer writes from software steer the address map
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        oag_pkg::STACK_POINTER_LOW_ADDR: next_r.sp  = reg_wdata_in;
        oag_pkg::WORKING_POINTER_0_ADDR: next_r.wp0 = reg_wdata_in;
        oag_pkg::WORKING_POINTER_1_ADDR: next_r.wp1 = reg_wdata_in;
        default: ;
      endcase
    end
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        oag_pkg::STACK_POINTER_LOW_ADDR: next_r.rdata = r.sp;
        oag_pkg::WORKING_POINTER_0_ADDR: next_r.rdata = r.wp0;
        oag_pkg::WORKING_POINTER_1_ADDR: next_r.rdata = r.wp1;
        default:                         next_r.rdata = 8'h00;
      endcase
    end

    // address request
    if (req_valid_in)
    begin
      next_r.valid    = 1'b1;
      next_r.error    = 1'b0;
      next_r.load_pc  = 1'b0;
      next_r.vector   = 1'b0;
      next_r.reg_addr = 8'h00;
      next_r.reg_data = 8'h00;
      next_r.mem_addr = 16'h0000;
      case (req_mode_in)
        oag_pkg::MODE_REGISTER:
        begin
          next_r.reg_addr = map_working(req_operand_in, r.wp0, r.wp1);
          // pair is high byte first, at the even address
          next_r.reg_data = req_operand_in[0] ? req_pair_in[7:0] : req_pair_in[15:8];
          next_r.mem_addr = req_pair_in;
        end
        oag_pkg::MODE_POINTER_VIA_REGISTER:
        begin
          next_r.reg_addr = req_index_in;
          next_r.mem_addr = req_pair_in;
          next_r.error    = in_protected(req_index_in, req_set1_in);
        end
        oag_pkg::MODE_INDEXED_REG:
        begin
          ea = req_operand_in + req_index_in;
          next_r.reg_addr = ea;
          next_r.error = in_protected(ea, req_set1_in)
                         || (req_op_in != oag_pkg::OP_PLAIN_LOAD);
        end
        oag_pkg::MODE_INDEXED_MEM_SHORT:
        begin
          next_r.mem_addr = req_pair_in + {{8{req_word_in[7]}}, req_word_in[7:0]};
          next_r.error    = !is_mem_load(req_op_in);
        end
        oag_pkg::MODE_INDEXED_MEM_LONG:
        begin
          next_r.mem_addr = req_pair_in + req_word_in;
          next_r.error    = !is_mem_load(req_op_in);
        end
        oag_pkg::MODE_ABSOLUTE_ADDRESS:
        begin
          next_r.mem_addr = req_word_in;
          next_r.load_pc  = (req_op_in == oag_pkg::OP_ABSOLUTE_JUMP) || (req_op_in == oag_pkg::OP_CALL);
          next_r.error    = !(next_r.load_pc || is_mem_load(req_op_in));
        end
        oag_pkg::MODE_VECTOR_TABLE_CALL:
        begin
          next_r.mem_addr = {8'h00, req_operand_in};
          next_r.vector   = 1'b1;
          next_r.error    = (req_op_in != oag_pkg::OP_CALL);
        end
        oag_pkg::MODE_PC_OFFSET:
        begin
          next_r.mem_addr = pc_in + {{8{req_operand_in[7]}}, req_operand_in};
          next_r.load_pc  = 1'b1;
          next_r.error    = !is_branch(req_op_in);
        end
        default: next_r.error = 1'b1;
      endcase
    end

    // stack sequencer; byte-wide pointer wraps inside the 256-byte file
    case (r.st)
      oag_pkg::ST_IDLE:
      begin
        if (call_in || int_entry_in)
        begin
          next_r.pc_hold  = pc_in;
          next_r.flg_hold = flags_in;
          next_r.st       = oag_pkg::ST_PUSH_PCL;
        end
        else if (interrupt_return_in)
          next_r.st = oag_pkg::ST_POP_FLG;
        else if (ret_in)
          next_r.st = oag_pkg::ST_POP_PCH;
        // remember whether flags follow the pc on the stack
        if (int_entry_in && !call_in)
          next_r.saddr = 8'h01;
        else if (call_in)
          next_r.saddr = 8'h00;
      end
      oag_pkg::ST_PUSH_PCL:
      begin
        next_r.sp     = r.sp - 8'h01;
        next_r.swdata = r.pc_hold[7:0];
        next_r.we     = 1'b1;
        next_r.st     = oag_pkg::ST_PUSH_PCH;
      end
      oag_pkg::ST_PUSH_PCH:
      begin
        next_r.sp     = r.sp - 8'h01;
        next_r.swdata = r.pc_hold[15:8];
        next_r.we     = 1'b1;
        next_r.st     = (r.saddr == 8'h01) ? oag_pkg::ST_PUSH_FLG : oag_pkg::ST_IDLE;
      end
      oag_pkg::ST_PUSH_FLG:
      begin
        next_r.sp     = r.sp - 8'h01;
        next_r.swdata = r.flg_hold;
        next_r.we     = 1'b1;
        next_r.st     = oag_pkg::ST_IDLE;
      end
      oag_pkg::ST_POP_FLG:
      begin
        next_r.flg_rest = stack_rdata_in;
        next_r.flg_load = 1'b1;
        next_r.sp       = r.sp + 8'h01;
        next_r.st       = oag_pkg::ST_POP_PCH;
      end
      oag_pkg::ST_POP_PCH:
      begin
        next_r.pc_rest[15:8] = stack_rdata_in;
        next_r.sp            = r.sp + 8'h01;
        next_r.st            = oag_pkg::ST_POP_PCL;
      end
      oag_pkg::ST_POP_PCL:
      begin
        next_r.pc_rest[7:0] = stack_rdata_in;
        next_r.pc_load      = 1'b1;
        next_r.sp           = r.sp + 8'h01;
        next_r.st           = oag_pkg::ST_IDLE;
      end
      default: next_r.st = oag_pkg::ST_IDLE;
    endcase

    // stack bus: write goes to the already decremented pointer, reads take the top
    case (next_r.st)
      oag_pkg::ST_POP_FLG,
      oag_pkg::ST_POP_PCH,
      oag_pkg::ST_POP_PCL: next_r.re = 1'b1;
      default:             next_r.re = 1'b0;
    endcase
    if (r.st != oag_pkg::ST_IDLE || next_r.re)
      next_r.saddr = r.saddr;
    // busy is its own flop so the output carries no decode
    next_r.busy = (next_r.st != oag_pkg::ST_IDLE);
  end

  // ********
  // registers
  // ********
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      r     <= '0;
      r.st  <= oag_pkg::ST_IDLE;
      r.wp0 <= oag_pkg::WORKING_POINTER_0_RST;
      r.wp1 <= oag_pkg::WORKING_POINTER_1_RST;
      r.sp  <= oag_pkg::STACK_POINTER_RST;
    end
    else
      r <= next_r;
  end

  // ********
  // outputs
  // ********
  assign reg_rdata_out     = r.rdata;
  assign res_valid_out     = r.valid;
  assign res_error_out     = r.error;
  assign res_reg_addr_out  = r.reg_addr;
  assign res_reg_data_out  = r.reg_data;
  assign res_mem_addr_out  = r.mem_addr;
  assign res_load_pc_out   = r.load_pc;
  assign res_vector_out    = r.vector;
  assign stack_busy_out    = r.busy;
  assign stack_we_out      = r.we;
  assign stack_re_out      = r.re;
  assign stack_addr_out    = r.sp;
  assign stack_wdata_out   = r.swdata;
  assign pc_load_out       = r.pc_load;
  assign pc_restore_out    = r.pc_rest;
  assign flags_load_out    = r.flg_load;
  assign flags_restore_out = r.flg_rest;

endmodule : oag_operand_address_generator

// >>> oag_regfile_model.sv
// partner: register file slice that holds the system stack
`timescale 1ns/1ns
module oag_regfile_model
(
  input  wire logic       sys_clk_in, // core clock
  input  wire logic       we_in,      // stack write
  input  wire logic       re_in,      // stack read
  input  wire logic [7:0] addr_in,    // stack location
  input  wire logic [7:0] wdata_in,   // pushed byte
  output logic      [7:0] rdata_out   // popped byte
);
  logic [7:0] mem [256];
  always_ff @(posedge sys_clk_in)
  begin
    if (we_in)
    begin
      mem[addr_in] <= wdata_in;
    end
  end
  // outside a read the data is inverted, so a stray sample never matches
  assign rdata_out = re_in ? mem[addr_in] : ~mem[addr_in];
endmodule : oag_regfile_model

// >>> oag_operand_address_generator_asserts.sv
// checker: port properties of the operand address generator
`timescale 1ns/1ns
module oag_asserts
(
  input wire logic               sys_clk_in,       // clock
  input wire logic               resetn_in,        // reset
  input wire logic               req_valid_in,     // request
  input wire oag_pkg::oag_mode_e req_mode_in,      // mode
  input wire oag_pkg::oag_op_e   req_op_in,        // class
  input wire logic [7:0]         req_operand_in,   // operand
  input wire logic [15:0]        req_word_in,      // word
  input wire logic [7:0]         req_index_in,     // index
  input wire logic [15:0]        pc_in,            // pc
  input wire logic               res_valid_out,    // strobe
  input wire logic               res_error_out,    // error
  input wire logic [7:0]         res_reg_addr_out, // reg address
  input wire logic [15:0]        res_mem_addr_out, // mem address
  input wire logic               call_in,          // call
  input wire logic               ret_in,           // return
  input wire logic               int_entry_in,     // interrupt
  input wire logic               stack_busy_out,   // busy
  input wire logic               stack_we_out,     // push
  input wire logic               stack_re_out,     // pop
  input wire logic [7:0]         stack_addr_out,   // pointer
  input wire logic               pc_load_out       // pc restore
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence push_two;
    !stack_we_out ##1 stack_we_out [*2] ##1 !stack_we_out;
  endsequence
  sequence push_three;
    !stack_we_out ##1 stack_we_out [*3] ##1 !stack_we_out;
  endsequence
  sequence pop_pc;
    stack_re_out [*2] ##1 pc_load_out;
  endsequence

  chk_abs_target: assert property (
    req_valid_in && req_mode_in == oag_pkg::MODE_ABSOLUTE_ADDRESS |=>
    res_valid_out && res_mem_addr_out == $past(req_word_in)) else $error("absolute target wrong");
  chk_pc_offset: assert property (
    req_valid_in && req_mode_in == oag_pkg::MODE_PC_OFFSET |=>
    res_mem_addr_out == $past(pc_in) + {{8{$past(req_operand_in[7])}}, $past(req_operand_in)})
    else $error("relative target wrong");
  chk_vector_call: assert property (
    req_valid_in && req_mode_in == oag_pkg::MODE_VECTOR_TABLE_CALL |=>
    res_mem_addr_out == {8'h00, $past(req_operand_in)} && res_error_out == ($past(req_op_in) != oag_pkg::OP_CALL))
    else $error("vector call wrong");
  chk_index_sum: assert property (
    req_valid_in && req_mode_in == oag_pkg::MODE_INDEXED_REG |=>
    res_reg_addr_out == $past(req_operand_in) + $past(req_index_in)) else $error("indexed sum wrong");
  chk_call_push: assert property (call_in && !stack_busy_out |=> push_two)
    else $error("call push sequence wrong");
  chk_int_push: assert property (int_entry_in && !stack_busy_out |=> push_three)
    else $error("interrupt push sequence wrong");
  chk_ret_pop: assert property (ret_in && !stack_busy_out |=> pop_pc)
    else $error("return pop sequence wrong");
  chk_push_dec: assert property (stack_we_out |-> stack_addr_out == $past(stack_addr_out) - 8'h01)
    else $error("push without predecrement");
  chk_pop_inc: assert property (
    stack_re_out && $past(stack_re_out) |-> stack_addr_out == $past(stack_addr_out) + 8'h01)
    else $error("pop without postincrement");
endmodule : oag_asserts

// >>> oag_operand_address_generator_tb.sv
// testbench: directed scenarios for the operand address generator
`timescale 1ns/1ns
module oag_operand_address_generator_tb;
  logic               sys_clk_in = 1'b0;
  logic               resetn_in = 1'b0;
  logic               reg_wr_in = 1'b0;
  logic               reg_rd_in = 1'b0;
  logic [7:0]         reg_addr_in = 8'h00;
  logic [7:0]         reg_wdata_in = 8'h00;
  logic               req_valid_in = 1'b0;
  logic               req_set1_in = 1'b0;
  oag_pkg::oag_mode_e req_mode_in = oag_pkg::MODE_REGISTER;
  oag_pkg::oag_op_e   req_op_in = oag_pkg::OP_OTHER;
  logic [7:0]         req_operand_in = 8'h00;
  logic [7:0]         req_index_in = 8'h00;
  logic [15:0]        req_word_in = 16'h0000;
  logic [15:0]        req_pair_in = 16'h1234;
  logic [15:0]        pc_in = 16'h2000;
  logic [7:0]         flags_in = 8'h00;
  logic               call_in = 1'b0;
  logic               ret_in = 1'b0;
  logic               int_entry_in = 1'b0;
  logic               interrupt_return_in = 1'b0;
  logic [7:0]         stack_rdata_in, reg_rdata_out, res_reg_addr_out, res_reg_data_out;
  logic [7:0]         stack_addr_out, stack_wdata_out, flags_restore_out, got_flags;
  logic [15:0]        res_mem_addr_out, pc_restore_out, got_pc;
  logic               res_valid_out, res_error_out, res_load_pc_out, res_vector_out, stack_busy_out;
  logic               stack_we_out, stack_re_out, pc_load_out, flags_load_out;
  int                 miscompares = 0;
  int                 tests_run = 0;

  always #20 sys_clk_in = ~sys_clk_in;

  oag_operand_address_generator uut (.sys_clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .req_valid_in, .req_mode_in, .req_op_in, .req_operand_in, .req_word_in,
    .req_pair_in, .req_index_in, .req_set1_in, .pc_in, .res_valid_out, .res_error_out, .res_reg_addr_out,
    .res_reg_data_out, .res_mem_addr_out, .res_load_pc_out, .res_vector_out, .call_in, .ret_in, .int_entry_in,
    .interrupt_return_in, .flags_in, .stack_rdata_in, .stack_busy_out, .stack_we_out, .stack_re_out,
    .stack_addr_out, .stack_wdata_out, .pc_load_out, .pc_restore_out, .flags_load_out, .flags_restore_out);
  oag_regfile_model rf (.sys_clk_in, .we_in(stack_we_out), .re_in(stack_re_out), .addr_in(stack_addr_out),
    .wdata_in(stack_wdata_out), .rdata_out(stack_rdata_in));

  always @(posedge sys_clk_in)
  begin
    if (pc_load_out) got_pc <= pc_restore_out;
    if (flags_load_out) got_flags <= flags_restore_out;
  end

  // ********
  // bus tasks
  // ********
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 cmp({8'h00, reg_rdata_out}, {8'h00, exp});
  endtask : rd
  // mode and class codes follow the package encodings
  task req(input logic [2:0] m, input logic [3:0] o, input logic [7:0] opd, input logic [15:0] w,
           input logic [7:0] idx, input logic s1);
    @(posedge sys_clk_in);
    req_valid_in <= 1'b1;
    req_mode_in <= oag_pkg::oag_mode_e'(m);
    req_op_in <= oag_pkg::oag_op_e'(o);
    req_operand_in <= opd;
    req_word_in <= w;
    req_index_in <= idx;
    req_set1_in <= s1;
    @(posedge sys_clk_in);
    req_valid_in <= 1'b0;
    #1 cmp({15'h0000, res_valid_out}, 16'h0001);
  endtask : req
  // pulse order: call, return, interrupt entry, interrupt return
  task stk(input logic [3:0] k, input logic [15:0] pc, input logic [7:0] fl);
    @(posedge sys_clk_in);
    {call_in, ret_in, int_entry_in, interrupt_return_in} <= k;
    pc_in <= pc;
    flags_in <= fl;
    @(posedge sys_clk_in);
    {call_in, ret_in, int_entry_in, interrupt_return_in} <= 4'h0;
    #1;
    for (int i = 0; i < 12 && stack_busy_out !== 1'b0; i++) @(posedge sys_clk_in);
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask : stk

  // ********
  // scenarios
  // ********
  task t_working;
    rd(8'hd6, 8'hc0);
    rd(8'hd7, 8'hc8);
    rd(8'hd8, 8'h00);
    wr(8'hd7, 8'ha8);
    req(3'h0, 4'h1, 8'hcb, 16'h0, 8'h0, 1'b0);
    cmp({8'h0, res_reg_addr_out}, 16'hab);
    wr(8'hd6, 8'h70);
    req(3'h0, 4'h1, 8'hc6, 16'h0, 8'h0, 1'b0);
    cmp({8'h0, res_reg_addr_out}, 16'h76);
    req(3'h0, 4'h1, 8'h45, 16'h0, 8'h0, 1'b0);
    cmp({8'h0, res_reg_addr_out}, 16'h45);
    cmp({8'h0, res_reg_data_out}, 16'h34);
    req(3'h0, 4'h1, 8'h44, 16'h0, 8'h0, 1'b0);
    cmp({8'h0, res_reg_data_out}, 16'h12);
  endtask : t_working
  task t_indexed;
    req(3'h2, 4'h1, 8'h10, 16'h0, 8'h20, 1'b0);
    cmp({8'h0, res_reg_addr_out}, 16'h30);
    cmp({15'h0, res_error_out}, 16'h0);
    req(3'h2, 4'h0, 8'h10, 16'h0, 8'h20, 1'b0);
    cmp({15'h0, res_error_out}, 16'h1);
    req(3'h2, 4'h1, 8'hb0, 16'h0, 8'h15, 1'b1);
    cmp({15'h0, res_error_out}, 16'h1);
    req(3'h1, 4'h1, 8'hc4, 16'h0, 8'hc4, 1'b1);
    cmp({15'h0, res_error_out}, 16'h1);
    req(3'h1, 4'h1, 8'hc4, 16'h0, 8'hc4, 1'b0);
    cmp({7'h0, res_error_out, res_reg_addr_out}, 16'hc4);
  endtask : t_indexed
  task t_memory;
    req(3'h3, 4'h2, 8'hfe, 16'hfe, 8'h0, 1'b0);
    cmp(res_mem_addr_out, 16'h1232);
    req(3'h4, 4'h3, 8'h0, 16'h100, 8'h0, 1'b0);
    cmp(res_mem_addr_out, 16'h1334);
    cmp({15'h0, res_error_out}, 16'h0);
    req(3'h3, 4'h1, 8'hfe, 16'hfe, 8'h0, 1'b0);
    cmp({15'h0, res_error_out}, 16'h1);
    req(3'h5, 4'h4, 8'h0, 16'h4321, 8'h0, 1'b0);
    cmp({14'h0, res_load_pc_out, res_error_out}, 16'h2);
    req(3'h6, 4'h5, 8'h40, 16'h0, 8'h0, 1'b0);
    cmp({15'h0, res_vector_out}, 16'h1);
    cmp(res_mem_addr_out, 16'h40);
    req(3'h6, 4'h4, 8'h40, 16'h0, 8'h0, 1'b0);
    cmp({15'h0, res_error_out}, 16'h1);
  endtask : t_memory
  task t_relative;
    for (int i = 6; i < 12; i++)
    begin
      req(3'h7, 4'(i), 8'h80, 16'h0, 8'h0, 1'b0);
      cmp({res_error_out, res_mem_addr_out[14:0]}, 16'h1f80);
    end
    req(3'h7, 4'h0, 8'h7f, 16'h0, 8'h0, 1'b0);
    cmp({15'h0, res_error_out}, 16'h1);
  endtask : t_relative
  task t_stack;
    wr(8'hd9, 8'h00);
    stk(4'h8, 16'hbeef, 8'h00);
    cmp({rf.mem[8'hff], rf.mem[8'hfe]}, 16'hefbe);
    rd(8'hd9, 8'hfe);
    stk(4'h4, 16'h0000, 8'h00);
    cmp(got_pc, 16'hbeef);
    stk(4'h2, 16'h1357, 8'h5a);
    cmp({8'h00, rf.mem[8'hfd]}, 16'h005a);
    stk(4'h1, 16'h0000, 8'h00);
    cmp(got_pc, 16'h1357);
    cmp({8'h0, got_flags}, 16'h5a);
    rd(8'hd9, 8'h00);
  endtask : t_stack

  initial
  begin
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    t_working;
    t_indexed;
    t_memory;
    t_relative;
    t_stack;
    end_sim;
  end
  initial
  begin
    #(40 * 5000);
    miscompares++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim;
  end
endmodule : oag_operand_address_generator_tb

bind oag_operand_address_generator oag_asserts chk (.sys_clk_in, .resetn_in, .req_valid_in, .req_mode_in,
  .req_op_in, .req_operand_in, .req_word_in, .req_index_in, .pc_in, .res_valid_out, .res_error_out,
  .res_reg_addr_out, .res_mem_addr_out, .call_in, .ret_in, .int_entry_in, .stack_busy_out, .stack_we_out,
  .stack_re_out, .stack_addr_out, .pc_load_out);
